// ==== core/dpw_top.sv ====
`default_nettype none
module dpw_top #(
   parameter int OUV_TIMER_CYC = dpw_pkg::OUV_TIMER_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] fb_trip_in,
   input wire logic [1:0] current_limit_sense_first_in,
   input wire logic [1:0] current_limit_sense_second_in,
   input wire logic [1:0] ouv_in,
   input wire logic undervoltage_shutdown_in,
   input wire logic overvoltage_shutdown_in,
   input wire logic reference_good,
   input wire logic enable_in,
   input wire logic polarity_sel_in,
   input wire logic aux_low_in,
   input wire logic aux_up_in,
   input wire logic sync_input,
   output logic aux_gate_out,
   output logic main_gate_out,
   output logic main_sync_rect_gate_out,
   output logic aux_run,
   output logic main_run,
   output logic soft_start_discharge,
   output logic sync_output
);
   localparam int NIN = 16;

   logic [NIN-1:0] raw, s1_q, s2_q;
   logic [1:0] fb, il1, il2, ouv, pwm;
   logic uv, ov, refg, en, pol, aux_low, aux_up;
   logic disabled, ext_fault, fault_or, any_ouv, kill0, kill1, main_ok;
   logic en_q, uv_q, tog_q, tog_d;
   dpw_pkg::dpw_state_t st_q, st_d;
   logic aux_run_q, aux_run_d, main_run_q, main_run_d, ssd_q, ssd_d;
   logic [31:0] ouv_cnt_q, ouv_cnt_d;
   logic ouv_fault_q, ouv_fault_d;
   logic aux_gate_q, aux_gate_d, main_gate_q, main_gate_d, rect_q, rect_d;
   logic [7:0] main_off_q, main_off_d, rect_off_q, rect_off_d;
   logic ack_q, ack_d, hit;
   logic [31:0] dat_q, dat_d, rd;
   logic sync_en_q, sync_en_d;
   logic [15:0] period_q, period_d;
   logic [7:0] novl_q, novl_d;

   dpw_clk_if ck ();

   // Pins are asynchronous to clk: two flops before any use
   assign raw = {fb_trip_in, current_limit_sense_first_in, current_limit_sense_second_in, ouv_in,
      undervoltage_shutdown_in, overvoltage_shutdown_in, reference_good,
      enable_in, polarity_sel_in, aux_low_in, aux_up_in, sync_input};

   for (genvar i = 0; i < NIN; i++) begin : g_sync
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= raw[i];
            s2_q[i] <= s1_q[i];
         end
      end
   end

   assign {fb, il1, il2, ouv, uv, ov, refg, en, pol, aux_low, aux_up} = s2_q[NIN-1:1];

   assign ck.sync_in = s2_q[0];
   assign ck.sync_en = sync_en_q;
   assign ck.period = period_q;

   dpw_osc u_osc (
      .clk(clk),
      .rst_b(rst_b),
      .ck(ck.osc)
   );

   for (genvar c = 0; c < 2; c++) begin : g_chan
      dpw_pwm_chan u_chan (
         .clk(clk),
         .rst_b(rst_b),
         .pulse(c == 0 ? ck.aux_pulse : ck.main_pulse),
         .run(c == 0 ? aux_run_q : main_run_q),
         .term(fb[c] | il1[c]),
         .trip2(il2[c]),
         .pwm(pwm[c])
      );
   end

   // Fault gathering and start sequence
   always_comb begin
      // A floating enable is pulled high at the pad, seen here as 1
      disabled = pol ? en : ~en;
      ext_fault = uv | ov | ~refg;
      fault_or = ext_fault | disabled | ouv_fault_q;
      tog_d = (st_q == dpw_pkg::ST_TFAULT) &
              (tog_q | (((en ^ en_q) | (uv ^ uv_q)) & aux_low));
      st_d = st_q;
      case (st_q)
         dpw_pkg::ST_OFF: begin
            if (!fault_or) begin
               st_d = dpw_pkg::ST_RUN;
            end
         end
         dpw_pkg::ST_RUN: begin
            if (ouv_fault_q) begin
               st_d = dpw_pkg::ST_TFAULT;
            end else if (disabled) begin
               st_d = dpw_pkg::ST_OFF;
            end else if (ext_fault || ck.sync_lost) begin
               st_d = dpw_pkg::ST_WAIT_LOW;
            end
         end
         dpw_pkg::ST_WAIT_LOW: begin
            if (ouv_fault_q) begin
               st_d = dpw_pkg::ST_TFAULT;
            end else if (!fault_or && aux_low) begin
               st_d = dpw_pkg::ST_RUN;
            end
         end
         dpw_pkg::ST_TFAULT: begin
            if (!fault_or && tog_q) begin
               st_d = dpw_pkg::ST_RUN;
            end
         end
         default: begin
            st_d = dpw_pkg::ST_OFF;
         end
      endcase
      aux_run_d = st_d == dpw_pkg::ST_RUN;
      main_run_d = aux_run_d & (main_run_q | aux_up);
      ssd_d = ~aux_run_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q <= dpw_pkg::ST_OFF;
         tog_q <= 1'b0;
         en_q <= 1'b0;
         uv_q <= 1'b0;
         aux_run_q <= 1'b0;
         main_run_q <= 1'b0;
         ssd_q <= 1'b1;
      end else begin
         st_q <= st_d;
         tog_q <= tog_d;
         en_q <= en;
         uv_q <= uv;
         aux_run_q <= aux_run_d;
         main_run_q <= main_run_d;
         ssd_q <= ssd_d;
      end
   end

   // Output undervoltage delay timer
   always_comb begin
      any_ouv = |ouv;
      ouv_cnt_d = ouv_cnt_q;
      ouv_fault_d = ouv_fault_q;
      if (!any_ouv) begin
         ouv_cnt_d = 32'h0000_0000;
         ouv_fault_d = 1'b0;
      end else if (ouv_cnt_q >= 32'(OUV_TIMER_CYC - 1)) begin
         ouv_fault_d = 1'b1;
      end else begin
         ouv_cnt_d = ouv_cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ouv_cnt_q <= 32'h0000_0000;
         ouv_fault_q <= 1'b0;
      end else begin
         ouv_cnt_q <= ouv_cnt_d;
         ouv_fault_q <= ouv_fault_d;
      end
   end

   // Gate drive with dead time on the main pair
   always_comb begin
      kill0 = fb[0] | il1[0] | il2[0];
      kill1 = fb[1] | il1[1] | il2[1];
      aux_gate_d = aux_run_q & ~fault_or & pwm[0] & ~kill0;
      main_ok = main_run_q & ~fault_or;
      main_gate_d = main_ok & pwm[1] & ~kill1 & ~rect_q &
                    (rect_off_q >= novl_q);
      rect_d = main_ok & (~pwm[1] | kill1) & ~main_gate_q &
               (main_off_q >= novl_q);
      main_off_d = main_gate_q ? 8'h00 : (&main_off_q ? main_off_q : main_off_q + 8'h01);
      rect_off_d = rect_q ? 8'h00 : (&rect_off_q ? rect_off_q : rect_off_q + 8'h01);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aux_gate_q <= 1'b0;
         main_gate_q <= 1'b0;
         rect_q <= 1'b0;
         main_off_q <= 8'h00;
         rect_off_q <= 8'h00;
      end else begin
         aux_gate_q <= aux_gate_d;
         main_gate_q <= main_gate_d;
         rect_q <= rect_d;
         main_off_q <= main_off_d;
         rect_off_q <= rect_off_d;
      end
   end

   // Wishbone classic slave, one wait state, unmapped reads as zero
   always_comb begin
      hit = wb_cyc_i & wb_stb_i & ~ack_q;
      ack_d = hit;
      sync_en_d = sync_en_q;
      period_d = period_q;
      novl_d = novl_q;
      rd = 32'h0000_0000;
      case (wb_adr_i)
         dpw_pkg::ADDR_CTRL: begin
            rd[dpw_pkg::CTRL_SYNC_EN] = sync_en_q;
         end
         dpw_pkg::ADDR_PERIOD: begin
            rd[15:0] = period_q;
         end
         dpw_pkg::ADDR_NOVL: begin
            rd[7:0] = novl_q;
         end
         dpw_pkg::ADDR_STATUS: begin
            rd[dpw_pkg::ST_AUX_RUN] = aux_run_q;
            rd[dpw_pkg::ST_MAIN_RUN] = main_run_q;
            rd[dpw_pkg::ST_OUV_FAULT] = ouv_fault_q;
            rd[dpw_pkg::ST_LOCKED] = ck.locked;
            rd[dpw_pkg::ST_STATE_LSB +: 2] = st_q;
         end
         default: begin
            rd = 32'h0000_0000;
         end
      endcase
      dat_d = hit ? rd : dat_q;
      if (hit && wb_we_i) begin
         if (wb_adr_i == dpw_pkg::ADDR_CTRL && wb_sel_i[0]) begin
            sync_en_d = wb_dat_i[dpw_pkg::CTRL_SYNC_EN];
         end
         if (wb_adr_i == dpw_pkg::ADDR_PERIOD) begin
            if (wb_sel_i[0]) begin
               period_d[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               period_d[15:8] = wb_dat_i[15:8];
            end
         end
         if (wb_adr_i == dpw_pkg::ADDR_NOVL && wb_sel_i[0]) begin
            novl_d = wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         sync_en_q <= dpw_pkg::CTRL_SYNC_EN_RST;
         period_q <= dpw_pkg::PERIOD_RST;
         novl_q <= dpw_pkg::NOVL_RST;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         sync_en_q <= sync_en_d;
         period_q <= period_d;
         novl_q <= novl_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign aux_gate_out = aux_gate_q;
   assign main_gate_out = main_gate_q;
   assign main_sync_rect_gate_out = rect_q;
   assign aux_run = aux_run_q;
   assign main_run = main_run_q;
   assign soft_start_discharge = ssd_q;
   assign sync_output = ck.sync_out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_fb_kill;
      fb[0] |=> !aux_gate_q;
   endproperty
   a_fb_kill: assert property (p_fb_kill) else $error("aux gate on during trip");
   property p_current_limit_sense_kill;
      il1[1] |=> !main_gate_q;
   endproperty
   a_current_limit_sense_kill: assert property (p_current_limit_sense_kill) else $error("main gate on in limit");
   property p_disable;
      disabled |=> !aux_gate_q && !main_gate_q && !rect_q;
   endproperty
   a_disable: assert property (p_disable) else $error("gates on while disabled");
   property p_ext_fault;
      ext_fault |=> !aux_run_q && !aux_gate_q;
   endproperty
   a_ext_fault: assert property (p_ext_fault) else $error("run kept under fault");
   property p_softstart;
      ssd_q == !aux_run_q;
   endproperty
   a_softstart: assert property (p_softstart) else $error("discharge mismatch");
   property p_timer_trip;
      any_ouv && ouv_cnt_q == 32'(OUV_TIMER_CYC - 1) |=> ouv_fault_q ##1 !main_gate_q;
   endproperty
   a_timer_trip: assert property (p_timer_trip) else $error("timer did not trip");
   property p_timer_clear;
      !any_ouv |=> !ouv_fault_q && ouv_cnt_q == 32'h0000_0000;
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");
   property p_nonoverlap;
      $fell(main_gate_q) |-> !rect_q [*2];
   endproperty
   a_nonoverlap: assert property (p_nonoverlap) else $error("no dead time");
   property p_main_after_aux;
      main_run_q |-> aux_run_q;
   endproperty
   a_main_after_aux: assert property (p_main_after_aux) else $error("main before aux");
endmodule : dpw_top
`default_nettype wire

// ==== pkg/dpw_pkg.sv ====
`default_nettype none
package dpw_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_KHZ = 100000;
   localparam int FREQ_NOM_KHZ = 512;
   localparam logic [15:0] PERIOD_RST = 16'(CLK_KHZ / FREQ_NOM_KHZ);
   localparam int PULSE_NS = 100;
   localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
   localparam int NOVL_NS = 45;
   localparam logic [7:0] NOVL_RST = 8'((NOVL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] BLANK_CYCLES = 2'h2;
   localparam int OUV_TIMER_CYC_DEF = 100000;
   // Sync capture window +25%/-35% in frequency, as period ratios 4/5 and 20/13
   localparam int WIN_LO_NUM = 4;
   localparam int WIN_LO_DEN = 5;
   localparam int WIN_HI_NUM = 20;
   localparam int WIN_HI_DEN = 13;
   localparam int STOP_PERIODS = 2;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_NOVL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam int CTRL_SYNC_EN = 0;
   localparam logic CTRL_SYNC_EN_RST = 1'b1;
   localparam int ST_AUX_RUN = 0;
   localparam int ST_MAIN_RUN = 1;
   localparam int ST_OUV_FAULT = 2;
   localparam int ST_LOCKED = 3;
   localparam int ST_STATE_LSB = 4;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_RUN = 2'b01,
      ST_WAIT_LOW = 2'b10,
      ST_TFAULT = 2'b11
   } dpw_state_t;
endpackage : dpw_pkg
`default_nettype wire

// ==== pkg/dpw_clk_if.sv ====
`default_nettype none
interface dpw_clk_if;
   logic main_pulse;
   logic aux_pulse;
   logic sync_out;
   logic locked;
   logic sync_lost;
   logic sync_en;
   logic sync_in;
   logic [15:0] period;
   modport osc (output main_pulse, aux_pulse, sync_out, locked, sync_lost,
      input sync_en, sync_in, period);
   modport ctl (input main_pulse, aux_pulse, sync_out, locked, sync_lost,
      output sync_en, sync_in, period);
endinterface : dpw_clk_if
`default_nettype wire

// ==== core/dpw_osc.sv ====
`default_nettype none
module dpw_osc (
   input wire logic clk,
   input wire logic rst_b,
   dpw_clk_if.osc ck
);
   logic [15:0] cnt_q, cnt_d, meas_q, meas_d, half;
   logic sin_q, sin_d, locked_q, locked_d, lost_q, lost_d;
   logic mp_q, mp_d, ap_q, ap_d, so_q, so_d, edge_s, in_win;

   always_comb begin
      half = {1'b0, ck.period[15:1]};
      edge_s = ck.sync_in & ~sin_q;
      in_win = (32'(meas_q) * 32'(dpw_pkg::WIN_LO_DEN) >=
                32'(ck.period) * 32'(dpw_pkg::WIN_LO_NUM)) &&
               (32'(meas_q) * 32'(dpw_pkg::WIN_HI_DEN) <=
                32'(ck.period) * 32'(dpw_pkg::WIN_HI_NUM));
      sin_d = ck.sync_in;
      meas_d = edge_s ? 16'h0001 : (&meas_q ? meas_q : meas_q + 16'h0001);
      cnt_d = (cnt_q >= ck.period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      locked_d = locked_q;
      lost_d = 1'b0;
      if (!ck.sync_en) begin
         locked_d = 1'b0;
      end else if (edge_s) begin
         locked_d = in_win;
         if (in_win) begin
            cnt_d = 16'h0000;
         end
      end else if (locked_q && 32'(meas_q) >
                   32'(ck.period) * 32'(dpw_pkg::STOP_PERIODS)) begin
         locked_d = 1'b0;
         lost_d = 1'b1;
      end
      mp_d = 32'(cnt_d) < 32'(dpw_pkg::PULSE_CYC);
      ap_d = cnt_d >= half && 32'(cnt_d) < 32'(half) + 32'(dpw_pkg::PULSE_CYC);
      so_d = cnt_d >= half;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_q <= 16'h0000;
         meas_q <= 16'hffff;
         sin_q <= 1'b0;
         locked_q <= 1'b0;
         lost_q <= 1'b0;
         mp_q <= 1'b0;
         ap_q <= 1'b0;
         so_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         meas_q <= meas_d;
         sin_q <= sin_d;
         locked_q <= locked_d;
         lost_q <= lost_d;
         mp_q <= mp_d;
         ap_q <= ap_d;
         so_q <= so_d;
      end
   end

   assign ck.main_pulse = mp_q;
   assign ck.aux_pulse = ap_q;
   assign ck.sync_out = so_q;
   assign ck.locked = locked_q;
   assign ck.sync_lost = lost_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_antiphase;
      !(mp_q && ap_q);
   endproperty
   a_antiphase: assert property (p_antiphase) else $error("clock pulses overlap");
   property p_sync_phase;
      ck.sync_en && locked_q && edge_s && in_win |=> mp_q && cnt_q == 16'h0000;
   endproperty
   a_sync_phase: assert property (p_sync_phase) else $error("sync not aligned");
endmodule : dpw_osc
`default_nettype wire

// ==== core/dpw_pwm_chan.sv ====
`default_nettype none
module dpw_pwm_chan (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pulse,
   input wire logic run,
   input wire logic term,
   input wire logic trip2,
   output logic pwm
);
   logic pulse_q, pwm_q, pwm_d, start;
   logic [1:0] blank_q, blank_d;

   always_comb begin
      start = pulse & ~pulse_q;
      blank_d = blank_q;
      pwm_d = pwm_q;
      if (start && blank_q != 2'h0) begin
         blank_d = blank_q - 2'h1;
      end
      // Set only at window start so a mid-cycle glitch cannot turn on
      if (start) begin
         pwm_d = ~term & (blank_q == 2'h0);
      end
      if (term) begin
         pwm_d = 1'b0;
      end
      if (trip2) begin
         pwm_d = 1'b0;
         blank_d = dpw_pkg::BLANK_CYCLES;
      end
      if (!run) begin
         pwm_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pulse_q <= 1'b0;
         pwm_q <= 1'b0;
         blank_q <= 2'h0;
      end else begin
         pulse_q <= pulse;
         pwm_q <= pwm_d;
         blank_q <= blank_d;
      end
   end

   assign pwm = pwm_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_blank;
      start && blank_q != 2'h0 |=> !pwm_q;
   endproperty
   a_blank: assert property (p_blank) else $error("gate on while blanked");
   property p_window;
      !pwm_q && !start |=> !pwm_q;
   endproperty
   a_window: assert property (p_window) else $error("turn-on outside window");
endmodule : dpw_pwm_chan
`default_nettype wire

// ==== test/dpw_stage_model.sv ====
`default_nettype none
module dpw_stage_model (
   input wire logic clk,
   input wire logic aux_gate,
   input wire logic main_gate,
   input wire logic aux_run,
   input wire logic trip_hold,
   output logic [1:0] fb_trip,
   output logic aux_up,
   output logic aux_low
);
   timeunit 1ns;
   timeprecision 1ps;
   int on_a = 0;
   int on_m = 0;
   int pulses = 0;
   int idle = 0;
   initial begin
      fb_trip = 2'h0;
      aux_up = 1'b0;
      aux_low = 1'b1;
   end
   // Loop ends each pulse after a fixed on-time; supply bleeds down slowly
   always @(posedge clk) begin
      on_a <= aux_gate ? on_a + 1 : 0;
      on_m <= main_gate ? on_m + 1 : 0;
      pulses <= !aux_run ? 0 : (aux_gate && on_a == 0) ? pulses + 1 : pulses;
      idle <= aux_run ? 0 : idle + 1;
      fb_trip[0] <= trip_hold || on_a >= 30;
      fb_trip[1] <= trip_hold || on_m >= 40;
      aux_up <= aux_run && pulses >= 3;
      aux_low <= idle > 20;
   end
endmodule : dpw_stage_model
`default_nettype wire

// ==== test/dual_pwm_fault_sync_control_tb.sv ====
`default_nettype none
module dual_pwm_fault_sync_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic chk; logic [31:0] m; logic [31:0] v;} dpw_note_t;
   logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic [1:0] fb, ilim1 = 2'h0, ilim2 = 2'h0, ouv = 2'h0;
   logic uv = 1'b0, ov = 1'b0, refg = 1'b1, en = 1'b0, pol = 1'b1, trip_hold = 1'b0;
   logic aux_low, aux_up, sync_in = 1'b0;
   logic aux_g, main_g, rect_g, aux_run, main_run, ssd, sync_o;
   dpw_note_t q[$];
   dpw_note_t nt;
   int mismatches = 0, tests_run = 0, sync_per = 0, sc = 0, h;
   logic [31:0] r;
   always #5 clk = ~clk;
   dpw_top #(.OUV_TIMER_CYC(50)) dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .fb_trip_in(fb), .current_limit_sense_first_in(ilim1),
      .current_limit_sense_second_in(ilim2), .ouv_in(ouv), .undervoltage_shutdown_in(uv),
      .overvoltage_shutdown_in(ov), .reference_good(refg), .enable_in(en),
      .polarity_sel_in(pol), .aux_low_in(aux_low), .aux_up_in(aux_up),
      .sync_input(sync_in), .aux_gate_out(aux_g), .main_gate_out(main_g),
      .main_sync_rect_gate_out(rect_g), .aux_run(aux_run), .main_run(main_run),
      .soft_start_discharge(ssd), .sync_output(sync_o));
   dpw_stage_model stage_u (.clk(clk), .aux_gate(aux_g), .main_gate(main_g),
      .aux_run(aux_run), .trip_hold(trip_hold), .fb_trip(fb), .aux_up(aux_up),
      .aux_low(aux_low));
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   // Every access leaves a note; the ack monitor consumes it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] m);
      int n;
      n = 0;
      q.push_back('{!w, m, d & m});
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= w ? d : 32'h0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         check("wb_ack_o", 32'h1, 32'h0);
         complete_run();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   always @(posedge clk) begin
      if (ack === 1'b1) begin
         if (q.size() == 0) check("wb_ack_o", 32'h0, 32'h1);
         else begin
            nt = q.pop_front();
            if (nt.chk) check("wb_dat_o", nt.v, rdat & nt.m);
         end
      end
      if ((main_g & rect_g) === 1'b1) check("gate_overlap", 32'h0, 32'h1);
      sc <= (sync_per == 0 || sc >= sync_per - 1) ? 0 : sc + 1;
      sync_in <= sync_per != 0 && sc < sync_per / 2;
   end
   function automatic logic pick(input int k);
      case (k)
         0: return aux_run;
         1: return main_run;
         2: return aux_g;
         default: return ssd;
      endcase
   endfunction : pick
   task automatic wait_sig(input int k, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(k) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      check($sformatf("signal %0d", k), {31'h0, v}, {31'h0, pick(k)});
      // Only a real miss ends the run; reaching the value on the last try is fine
      if (pick(k) !== v) complete_run();
   endtask : wait_sig
   task automatic count_on(input int n, input logic [1:0] m);
      h = 0;
      repeat (n) begin
         @(posedge clk);
         if (((m[0] & aux_g) | (m[1] & main_g)) === 1'b1) h++;
      end
   endtask : count_on
   initial begin
      void'($urandom(29669));
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      check("soft_start_discharge", 32'h1, {31'h0, ssd});
      wb(1'b0, dpw_pkg::ADDR_CTRL, 32'h1, 32'hffffffff);
      wb(1'b0, dpw_pkg::ADDR_PERIOD, {16'h0, dpw_pkg::PERIOD_RST}, 32'hffffffff);
      wb(1'b0, dpw_pkg::ADDR_NOVL, {24'h0, dpw_pkg::NOVL_RST}, 32'hffffffff);
      wb(1'b1, 8'h10, 32'h5a, 32'hffffffff);
      wb(1'b0, 8'h10, 32'h0, 32'hffffffff);
      r = 32'(195 + $urandom % 8);
      wb(1'b1, dpw_pkg::ADDR_PERIOD, r, 32'hffffffff);
      wb(1'b0, dpw_pkg::ADDR_PERIOD, r, 32'hffffffff);
      wb(1'b1, dpw_pkg::ADDR_PERIOD, 32'd195, 32'hffffffff);
      $display("test registers done");
      wait_sig(0, 1'b1, 100);
      check("soft_start_discharge", 32'h0, {31'h0, ssd});
      wait_sig(1, 1'b1, 3000);
      $display("test startup done");
      wait_sig(2, 1'b1, 400);
      ilim1[0] <= 1'b1;
      repeat (4) @(posedge clk);
      check("aux_gate_out", 32'h0, {31'h0, aux_g});
      ilim1[0] <= 1'b0;
      ilim2[1] <= 1'b1;
      repeat (2) @(posedge clk);
      ilim2[1] <= 1'b0;
      repeat (3) @(posedge clk);
      count_on(370, 2'b10);
      check("main_gate_high_cycles", 32'h0, 32'(h));
      trip_hold <= 1'b1;
      repeat (4) @(posedge clk);
      count_on(400, 2'b11);
      check("gate_high_cycles", 32'h0, 32'(h));
      trip_hold <= 1'b0;
      $display("test trips done");
      uv <= 1'b1;
      wait_sig(0, 1'b0, 10);
      check("gates", 32'h0, {29'h0, aux_g, main_g, rect_g});
      check("soft_start_discharge", 32'h1, {31'h0, ssd});
      uv <= 1'b0;
      repeat (8) @(posedge clk);
      check("aux_run", 32'h0, {31'h0, aux_run});
      wait_sig(0, 1'b1, 100);
      $display("test supply fault done");
      for (int p = 1; p >= 0; p--) begin
         pol <= p[0];
         en <= !p[0];
         wait_sig(0, 1'b1, 3000);
         en <= p[0];
         wait_sig(0, 1'b0, 10);
         check("gates", 32'h0, {29'h0, aux_g, main_g, rect_g});
         en <= !p[0];
         wait_sig(0, 1'b1, 10);
         check("main_run", 32'h0, {31'h0, main_run});
      end
      $display("test enable done");
      wait_sig(1, 1'b1, 3000);
      ouv <= 2'b01;
      repeat (35) @(posedge clk);
      ouv <= 2'b00;
      repeat (3) @(posedge clk);
      ouv <= 2'b10;
      repeat (35) @(posedge clk);
      check("aux_run", 32'h1, {31'h0, aux_run});
      repeat (30) @(posedge clk);
      wait_sig(0, 1'b0, 10);
      check("gates", 32'h0, {29'h0, aux_g, main_g, rect_g});
      wb(1'b0, dpw_pkg::ADDR_STATUS, 32'h34, 32'h37);
      ouv <= 2'b00;
      repeat (40) @(posedge clk);
      check("aux_run", 32'h0, {31'h0, aux_run});
      en <= 1'b0;
      repeat (5) @(posedge clk);
      en <= 1'b1;
      wait_sig(0, 1'b1, 3000);
      $display("test output timer done");
      wait_sig(1, 1'b1, 3000);
      h = 0;
      repeat (dpw_pkg::PERIOD_RST) begin
         @(posedge clk);
         if (sync_o === 1'b1) h++;
      end
      r = 32'(dpw_pkg::PERIOD_RST) - 32'(dpw_pkg::PERIOD_RST >> 1);
      check("sync_output_high", r, 32'(h));
      sync_per = 200;
      repeat (1000) @(posedge clk);
      wb(1'b0, dpw_pkg::ADDR_STATUS, 32'h8, 32'h8);
      wb(1'b1, dpw_pkg::ADDR_CTRL, 32'h0, 32'hffffffff);
      wb(1'b0, dpw_pkg::ADDR_STATUS, 32'h0, 32'h8);
      wb(1'b1, dpw_pkg::ADDR_CTRL, 32'h1, 32'hffffffff);
      sync_per = 100;
      repeat (800) @(posedge clk);
      wb(1'b0, dpw_pkg::ADDR_STATUS, 32'h0, 32'h8);
      check("aux_run", 32'h1, {31'h0, aux_run});
      sync_per = 200;
      repeat (1000) @(posedge clk);
      sync_per = 0;
      wait_sig(0, 1'b0, 700);
      wait_sig(0, 1'b1, 300);
      $display("test sync done");
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clk);
      check("run_length", 32'h0, 32'h1);
      complete_run();
   end
endmodule : dual_pwm_fault_sync_control_tb
`default_nettype wire
